/* File: logic/lvd_defines.svh */
// Purpose: Offsets, field positions and reset values of the low-voltage monitor registers
// Assumes: 32-bit AXI4-Lite data, one register per aligned word
// Notes:   Definitions only
`ifndef LVD_DEFINES_SVH
`define LVD_DEFINES_SVH

// ==========================================================
// Register byte offsets
`define LVD_OFS_CONTROL   8'h00
`define LVD_OFS_STATUS    8'h04
`define LVD_OFS_IRQ_STAT  8'h08
`define LVD_OFS_IRQ_MASK  8'h0C

// ==========================================================
// Control register fields
`define LVD_CTL_MASTER_EN 7
`define LVD_CTL_THR_SEL   3
`define LVD_CTL_RST_EN    2
`define LVD_CTL_FALL_EN   1
`define LVD_CTL_RISE_EN   0
`define LVD_CTL_ONES      8'h70
`define LVD_CTL_RESET     8'h00

// ==========================================================
// Status register fields
`define LVD_STA_FALL      1
`define LVD_STA_RISE      0
`define LVD_STA_ONES      8'hFC
`define LVD_STA_RESET     2'h0

// ==========================================================
// Interrupt status and mask fields
`define LVD_IRQ_FALL      0
`define LVD_IRQ_RISE      1
`define LVD_IRQ_RESET     2'h0

// ==========================================================
// Bus answers
`define LVD_RESP_OKAY     2'h0
`define LVD_RESP_SLVERR   2'h2

`endif

/* File: logic/lvd_evt_if.sv */
// Purpose: Carrier between register logic and supply tracker
// Assumes: One clock domain
// Notes:   Comparator levels are taken as synchronous
`timescale 1ns/1ps
interface lvd_evt_if;
	logic below_fall;   // Supply under falling interrupt level
	logic above_rise;   // Supply over rising interrupt level
	logic below_reset;  // Supply under selected reset level
	logic active;       // Monitor enabled and not in its own reset
	logic rise_en;      // Rise interrupt enable
	logic fall_evt;     // One-cycle fall detection
	logic rise_evt;     // One-cycle recovery detection

	modport regs (output below_fall, output above_rise, output below_reset, output active,
	              output rise_en, input fall_evt, input rise_evt);
	modport trk  (input below_fall, input above_rise, input below_reset, input active,
	              input rise_en, output fall_evt, output rise_evt);
endinterface : lvd_evt_if

/* File: logic/lvd_pkg.sv */
// Purpose: Types shared by the low-voltage monitor modules
// Assumes: Constants live in lvd_defines.svh
// Notes:   Types only
package lvd_pkg;

	// ==========================================================
	// Supply tracking states; one bit per step IDLE-ARMED-LOW, two bits between IDLE and LOW
	typedef enum logic [1:0] {
		LVD_TRK_IDLE  = 2'h0,
		LVD_TRK_ARMED = 2'h1,
		LVD_TRK_LOW   = 2'h3
	} lvd_trk_t;

	// AXI response code
	typedef logic [1:0] lvd_resp_t;

endpackage : lvd_pkg

/* File: logic/lvd_regs.sv */
// Purpose: Control and status registers of the supply-voltage monitor
// Assumes: AXI4-Lite slave, comparator levels synchronous to clk_sys
// Notes:   Analog comparators and reset release counting live outside
//
// Local design decisions: the AXI4-Lite slave port and the register addresses.
`timescale 1ns/1ps
`include "lvd_defines.svh"
module lvd_regs #(
	parameter int ADDR_W = 8
) (
	// Clock and resets
	input  wire logic              clk_sys,
	input  wire logic              rst,
	input  wire logic              wdt_rst,
	// AXI4-Lite write channels
	input  wire logic [ADDR_W-1:0] s_axi_awaddr,
	input  wire logic              s_axi_awvalid,
	output      logic              s_axi_awready,
	input  wire logic [31:0]       s_axi_wdata,
	input  wire logic [3:0]        s_axi_wstrb,
	input  wire logic              s_axi_wvalid,
	output      logic              s_axi_wready,
	output      lvd_pkg::lvd_resp_t s_axi_bresp,
	output      logic              s_axi_bvalid,
	input  wire logic              s_axi_bready,
	// AXI4-Lite read channels
	input  wire logic [ADDR_W-1:0] s_axi_araddr,
	input  wire logic              s_axi_arvalid,
	output      logic              s_axi_arready,
	output      logic [31:0]       s_axi_rdata,
	output      lvd_pkg::lvd_resp_t s_axi_rresp,
	output      logic              s_axi_rvalid,
	input  wire logic              s_axi_rready,
	// Analog comparators
	input  wire logic              cmp_below_fall,
	input  wire logic              cmp_above_rise,
	input  wire logic              cmp_below_reset,
	// Analog controls and results
	output      logic              monitor_master_enable,
	output      logic              reset_threshold_select,
	output      logic              undervolt_reset_function,
	output      logic              external_irq_zero,
	output      logic              irq
);
	import lvd_pkg::*;

	// Offsets up to 0x0C need four address bits; the decoder widens to eight at most
	if (ADDR_W < 4 || ADDR_W > 8) begin : g_bad_addr_w
		$error("lvd_regs: ADDR_W must be 4 to 8");
	end

	// ==========================================================
	// Address decode shared by read and write
	function automatic logic [2:0] reg_sel(input logic [ADDR_W-1:0] a);
		logic [7:0] b;
		b = 8'(a);
		unique case (b)
			`LVD_OFS_CONTROL:  reg_sel = 3'h1;
			`LVD_OFS_STATUS:   reg_sel = 3'h2;
			`LVD_OFS_IRQ_STAT: reg_sel = 3'h3;
			`LVD_OFS_IRQ_MASK: reg_sel = 3'h4;
			default:           reg_sel = 3'h0;
		endcase
	endfunction : reg_sel

	// Combined reset, declared ahead of the tracker that uses it
	logic              full_rst;

	lvd_evt_if evt ();

	lvd_tracker u_trk (
		.clk_sys (clk_sys),
		.rst     (full_rst),
		.evt     (evt)
	);

	// ==========================================================
	// State
	logic              aw_have_r, aw_have_nxt;
	logic [ADDR_W-1:0] aw_addr_r, aw_addr_nxt;
	logic              w_have_r, w_have_nxt;
	logic [31:0]       w_data_r, w_data_nxt;
	logic              w_lane0_r, w_lane0_nxt;
	logic              bvalid_r, bvalid_nxt;
	lvd_resp_t         bresp_r, bresp_nxt;
	logic              rvalid_r, rvalid_nxt;
	lvd_resp_t         rresp_r, rresp_nxt;
	logic [31:0]       rdata_r, rdata_nxt;
	logic              en_r, en_nxt;
	logic              sel_r, sel_nxt;
	logic              rst_en_r, rst_en_nxt;
	logic              fall_en_r, fall_en_nxt;
	logic              rise_en_r, rise_en_nxt;
	logic [1:0]        flags_r, flags_nxt;
	logic [1:0]        seen_r, seen_nxt;
	logic [1:0]        ists_r, ists_nxt;
	logic [1:0]        mask_r, mask_nxt;
	logic              uv_rst_r, uv_rst_nxt;
	logic              external_irq_zero_r, external_irq_zero_nxt;
	logic              irq_r, irq_nxt;
	logic              do_write;
	logic              do_read;
	logic [2:0]        wsel;
	logic [2:0]        rsel;
	logic [1:0]        flag_set;
	logic [1:0]        irq_evt;

	// Watchdog reset acts like power-on for every bit
	assign full_rst = rst | wdt_rst;

	// ==========================================================
	// Tracker hookup; idle unless enabled and out of own reset
	assign evt.below_fall  = cmp_below_fall;
	assign evt.above_rise  = cmp_above_rise;
	assign evt.below_reset = cmp_below_reset;
	assign evt.active      = en_r & ~uv_rst_r;
	assign evt.rise_en     = rise_en_r;

	// ==========================================================
	// Bus strobes
	assign do_write = aw_have_r & w_have_r & ~bvalid_r;
	assign do_read  = s_axi_arvalid & ~rvalid_r;
	assign wsel     = reg_sel(aw_addr_r);
	assign rsel     = reg_sel(s_axi_araddr);

	// Flag sources; a set beats a simultaneous write clear, own reset beats a set
	assign flag_set[`LVD_STA_FALL] = evt.fall_evt;
	assign flag_set[`LVD_STA_RISE] = evt.rise_evt & rise_en_r;
	assign irq_evt[`LVD_IRQ_FALL]  = evt.fall_evt & fall_en_r;
	assign irq_evt[`LVD_IRQ_RISE]  = evt.rise_evt & rise_en_r;

	// ==========================================================
	// Write path: address and data taken in either order
	always_comb begin
		aw_have_nxt = aw_have_r;
		aw_addr_nxt = aw_addr_r;
		w_have_nxt  = w_have_r;
		w_data_nxt  = w_data_r;
		w_lane0_nxt = w_lane0_r;
		bvalid_nxt  = bvalid_r;
		bresp_nxt   = bresp_r;
		if (s_axi_awvalid && !aw_have_r) begin
			aw_have_nxt = 1'b1;
			aw_addr_nxt = s_axi_awaddr;
		end
		if (s_axi_wvalid && !w_have_r) begin
			w_have_nxt  = 1'b1;
			w_data_nxt  = s_axi_wdata;
			w_lane0_nxt = s_axi_wstrb[0];
		end
		if (do_write) begin
			aw_have_nxt = 1'b0;
			w_have_nxt  = 1'b0;
			bvalid_nxt  = 1'b1;
			bresp_nxt   = (wsel == 3'h0) ? `LVD_RESP_SLVERR : `LVD_RESP_OKAY;
		end
		if (bvalid_r && s_axi_bready) begin
			bvalid_nxt = 1'b0;
		end
	end

	// ==========================================================
	// Read path: one-cycle answer from registers
	always_comb begin
		rvalid_nxt = rvalid_r;
		rresp_nxt  = rresp_r;
		rdata_nxt  = rdata_r;
		if (do_read) begin
			rvalid_nxt = 1'b1;
			rresp_nxt  = `LVD_RESP_OKAY;
			unique case (rsel)
				3'h1: rdata_nxt = {24'h0, en_r, 3'h7, sel_r, rst_en_r, fall_en_r, rise_en_r};
				3'h2: rdata_nxt = {24'h0, 6'h3F, flags_r};
				3'h3: rdata_nxt = {30'h0, ists_r};
				3'h4: rdata_nxt = {30'h0, mask_r};
				default: begin
					rdata_nxt = 32'h0;
					rresp_nxt = `LVD_RESP_SLVERR;
				end
			endcase
		end else if (rvalid_r && s_axi_rready) begin
			rvalid_nxt = 1'b0;
		end
	end

	// ==========================================================
	// Control, flags and interrupts
	always_comb begin
		en_nxt      = en_r;
		sel_nxt     = sel_r;
		rst_en_nxt  = rst_en_r;
		fall_en_nxt = fall_en_r;
		rise_en_nxt = rise_en_r;
		flags_nxt   = flags_r;
		seen_nxt    = seen_r;
		ists_nxt    = ists_r;
		mask_nxt    = mask_r;
		// Writes only touch low byte; reserved bits have no storage
		if (do_write && w_lane0_r) begin
			unique case (wsel)
				3'h1: begin
					en_nxt      = w_data_r[`LVD_CTL_MASTER_EN];
					sel_nxt     = w_data_r[`LVD_CTL_THR_SEL];
					rst_en_nxt  = w_data_r[`LVD_CTL_RST_EN];
					fall_en_nxt = w_data_r[`LVD_CTL_FALL_EN];
					rise_en_nxt = w_data_r[`LVD_CTL_RISE_EN];
				end
				// Zero clears only a flag seen as one; one keeps it
				3'h2: flags_nxt = flags_r & ~(~w_data_r[1:0] & seen_r);
				3'h3: ists_nxt  = ists_r & ~w_data_r[1:0];
				3'h4: mask_nxt  = w_data_r[1:0];
				default: ;
			endcase
		end
		// Any status write consumes the read-as-one history
		if (do_write && wsel == 3'h2) begin
			seen_nxt = 2'h0;
		end
		// Read marks flags seen as one; the later write may clear them
		if (do_read && rsel == 3'h2) begin
			seen_nxt = flags_r;
		end
		flags_nxt = flags_nxt | flag_set;  // Set wins over clear
		ists_nxt  = ists_nxt | irq_evt;
		// Own reset clears flags, their read history and interrupt enables only
		if (uv_rst_r) begin
			fall_en_nxt = 1'b0;
			rise_en_nxt = 1'b0;
			flags_nxt   = `LVD_STA_RESET;
			seen_nxt    = 2'h0;
		end
	end

	// Reset request while enabled, armed and below level
	assign uv_rst_nxt = en_r & rst_en_r & cmp_below_reset;
	// Request in the cycle the enabled flag is set
	assign external_irq_zero_nxt   = |irq_evt;
	assign irq_nxt    = |(ists_nxt & mask_nxt);

	// ==========================================================
	// Registers under full reset
	always_ff @(posedge clk_sys) begin
		if (full_rst) begin
			aw_have_r <= 1'b0;
			aw_addr_r <= '0;
			w_have_r  <= 1'b0;
			w_data_r  <= 32'h0;
			w_lane0_r <= 1'b0;
			bvalid_r  <= 1'b0;
			bresp_r   <= `LVD_RESP_OKAY;
			rvalid_r  <= 1'b0;
			rresp_r   <= `LVD_RESP_OKAY;
			rdata_r   <= 32'h0;
			en_r      <= 1'b0;
			sel_r     <= 1'b0;
			rst_en_r  <= 1'b0;
			fall_en_r <= 1'b0;
			rise_en_r <= 1'b0;
			flags_r   <= `LVD_STA_RESET;
			seen_r    <= 2'h0;
			ists_r    <= `LVD_IRQ_RESET;
			mask_r    <= `LVD_IRQ_RESET;
			uv_rst_r  <= 1'b0;
			external_irq_zero_r    <= 1'b0;
			irq_r     <= 1'b0;
		end else begin
			aw_have_r <= aw_have_nxt;
			aw_addr_r <= aw_addr_nxt;
			w_have_r  <= w_have_nxt;
			w_data_r  <= w_data_nxt;
			w_lane0_r <= w_lane0_nxt;
			bvalid_r  <= bvalid_nxt;
			bresp_r   <= bresp_nxt;
			rvalid_r  <= rvalid_nxt;
			rresp_r   <= rresp_nxt;
			rdata_r   <= rdata_nxt;
			en_r      <= en_nxt;
			sel_r     <= sel_nxt;
			rst_en_r  <= rst_en_nxt;
			fall_en_r <= fall_en_nxt;
			rise_en_r <= rise_en_nxt;
			flags_r   <= flags_nxt;
			seen_r    <= seen_nxt;
			ists_r    <= ists_nxt;
			mask_r    <= mask_nxt;
			uv_rst_r  <= uv_rst_nxt;
			external_irq_zero_r    <= external_irq_zero_nxt;
			irq_r     <= irq_nxt;
		end
	end

	// ==========================================================
	// Outputs, all from flip-flops
	assign s_axi_awready            = ~aw_have_r;
	assign s_axi_wready             = ~w_have_r;
	assign s_axi_bvalid             = bvalid_r;
	assign s_axi_bresp              = bresp_r;
	assign s_axi_arready            = ~rvalid_r;  // One read in flight
	assign s_axi_rvalid             = rvalid_r;
	assign s_axi_rresp              = rresp_r;
	assign s_axi_rdata              = rdata_r;
	assign monitor_master_enable    = en_r;
	assign reset_threshold_select   = sel_r;
	assign undervolt_reset_function = uv_rst_r;
	assign external_irq_zero        = external_irq_zero_r;
	assign irq                      = irq_r;

endmodule : lvd_regs

/* File: logic/lvd_tracker.sv */
// Purpose: Turns comparator levels into fall and recovery events
// Assumes: Comparator levels synchronous to clk_sys
// Notes:   Held idle while the monitor is off
`timescale 1ns/1ps
module lvd_tracker (
	// Clock and reset
	input  wire logic clk_sys,
	input  wire logic rst,
	// Link to register logic
	lvd_evt_if.trk    evt
);
	import lvd_pkg::*;

	lvd_trk_t state_r;
	lvd_trk_t state_nxt;
	logic     fall_r;
	logic     fall_nxt;
	logic     rise_r;
	logic     rise_nxt;

	// ==========================================================
	// Next state
	always_comb begin
		state_nxt = state_r;
		fall_nxt  = 1'b0;
		rise_nxt  = 1'b0;
		if (!evt.active) begin
			state_nxt = LVD_TRK_IDLE;  // Standby: comparators ignored
		end else begin
			unique case (state_r)
				LVD_TRK_IDLE: begin
					if (evt.below_fall) begin
						fall_nxt  = 1'b1;
						// Recovery only counts if armed at the fall
						state_nxt = evt.rise_en ? LVD_TRK_ARMED : LVD_TRK_LOW;
					end
				end
				LVD_TRK_ARMED: begin
					if (evt.below_reset) begin
						state_nxt = LVD_TRK_LOW;  // Dropped too far, no rise event
					end else if (evt.above_rise) begin
						rise_nxt  = 1'b1;
						state_nxt = LVD_TRK_IDLE;
					end
				end
				LVD_TRK_LOW: begin
					if (evt.above_rise) begin
						state_nxt = LVD_TRK_IDLE;
					end
				end
				default: state_nxt = LVD_TRK_IDLE;
			endcase
		end
	end

	// ==========================================================
	// State registers
	always_ff @(posedge clk_sys) begin
		if (rst) begin
			state_r <= LVD_TRK_IDLE;
			fall_r  <= 1'b0;
			rise_r  <= 1'b0;
		end else begin
			state_r <= state_nxt;
			fall_r  <= fall_nxt;
			rise_r  <= rise_nxt;
		end
	end

	assign evt.fall_evt = fall_r;
	assign evt.rise_evt = rise_r;

endmodule : lvd_tracker

/* File: testbench/lvd_cmp_model.sv */
// Purpose: Supply comparator model
// Assumes: Supply given in millivolts
// Notes:   Levels move just after clk_sys
`timescale 1ns/1ps
module lvd_cmp_model (
	// Clock and supply
	input logic        clk_sys,
	input logic [15:0] supply_mv,
	input logic        thr_sel,
	// Comparator levels
	output logic       below_fall,
	output logic       above_rise,
	output logic       below_rst
);
	// Registered, real comparators settle late
	always @(posedge clk_sys) begin
		below_fall <= supply_mv < 16'd3700;
		above_rise <= supply_mv > 16'd4000;
		below_rst  <= supply_mv < (thr_sel ? 16'd3600 : 16'd2300);
	end
endmodule : lvd_cmp_model

/* File: testbench/lvd_regs_asserts.sv */
// Purpose: Port checks on the monitor registers
// Assumes: Bound into every lvd_regs
// Notes:   Sees ports only
`timescale 1ns/1ps
module lvd_regs_asserts #(
	parameter int ADDR_W = 8
) (
	// Clock and resets
	input logic              clk_sys,
	input logic              rst,
	input logic              wdt_rst,
	// Register bus
	input logic [ADDR_W-1:0] s_axi_awaddr,
	input logic              s_axi_awvalid,
	input logic              s_axi_awready,
	input logic [31:0]       s_axi_wdata,
	input logic [3:0]        s_axi_wstrb,
	input logic              s_axi_wvalid,
	input logic              s_axi_wready,
	input logic              s_axi_bvalid,
	input logic [ADDR_W-1:0] s_axi_araddr,
	input logic              s_axi_arvalid,
	input logic              s_axi_arready,
	input logic [31:0]       s_axi_rdata,
	input logic              s_axi_rvalid,
	// Supply side
	input logic              cmp_below_reset,
	input logic              monitor_master_enable,
	input logic              reset_threshold_select,
	input logic              undervolt_reset_function,
	input logic              external_irq_zero,
	input logic              irq
);
	default clocking cb @(posedge clk_sys); endclocking
	default disable iff (rst || wdt_rst);
	// ==========================================================
	// Accepted accesses
	sequence ctl_take;
		s_axi_awvalid && s_axi_awready && s_axi_wvalid && s_axi_wready && s_axi_wstrb[0] && s_axi_awaddr == 8'h00;
	endsequence
	sequence sta_take;
		s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04;
	endsequence
	// ==========================================================
	// Register behaviour
	ctl_apply_a:
	assert property (ctl_take |-> ##3 monitor_master_enable == $past(s_axi_wdata[7], 3)
		&& reset_threshold_select == $past(s_axi_wdata[3], 3)) else $error("control not applied");
	sta_ones_a:
	assert property (sta_take |=> s_axi_rvalid && s_axi_rdata[31:2] == 30'h3F) else $error("status fixed bits");
	ctl_ones_a:
	assert property (s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00 |=> s_axi_rdata[6:4] == 3'h7)
		else $error("control fixed bits");
	uv_cause_a:
	assert property (undervolt_reset_function |-> $past(cmp_below_reset) && $past(monitor_master_enable))
		else $error("reset without cause");
	pulse_en_a:
	assert property (external_irq_zero |-> monitor_master_enable && !$past(external_irq_zero))
		else $error("bad interrupt pulse");
	wdt_clear_a:
	assert property ($fell(wdt_rst) |-> !monitor_master_enable && !reset_threshold_select && !irq)
		else $error("watchdog reset left state");
	// Read closed while its answer stands; write answered only once both parts were held
	rd_busy_a: assert property (s_axi_rvalid |-> !s_axi_arready) else $error("read accepted early");
	wr_busy_a: assert property ($rose(s_axi_bvalid) |-> $past(!s_axi_awready && !s_axi_wready))
		else $error("write answered before both parts held");
endmodule : lvd_regs_asserts
bind lvd_regs lvd_regs_asserts #(.ADDR_W(ADDR_W)) u_lvd_chk (.*);

/* File: testbench/tb_top.sv */
// Purpose: Self-checking bench of the monitor registers
// Assumes: Model and design leave reset together
// Notes:   Supply moved through a comparator model
`timescale 1ns/1ps
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin mismatches++; \
	$display("BAD t=%0t got=%h exp=%h", $time, g, e); end end
module tb_top;
	import lvd_pkg::*;
	// ==========================================================
	// Design ports and model state
	logic        clk_sys = 1'b0, rst = 1'b1, wdt_rst = 1'b0;
	logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
	logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, d;
	logic [3:0]  s_axi_wstrb = 4'hF;
	logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
	logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0;
	logic        s_axi_awready, s_axi_wready, s_axi_bvalid, s_axi_arready, s_axi_rvalid;
	lvd_resp_t   s_axi_bresp, s_axi_rresp;
	logic        cmp_below_fall, cmp_above_rise, cmp_below_reset, irq, external_irq_zero;
	logic        monitor_master_enable, reset_threshold_select, undervolt_reset_function;
	logic [15:0] mv = 16'd5000;
	int          mismatches = 0, samples_checked = 0, pulses;
	int          ctl = 0, fl = 0, hist = 0, ist = 0, msk = 0;
	int          legal[4] = '{8'h8C, 8'h82, 8'h83, 8'h87};
	always #25 clk_sys = ~clk_sys;
	lvd_regs dut (.*);
	lvd_cmp_model u_cmp (.clk_sys(clk_sys), .supply_mv(mv), .thr_sel(reset_threshold_select),
		.below_fall(cmp_below_fall), .above_rise(cmp_above_rise), .below_rst(cmp_below_reset));
	// ==========================================================
	// Verdict and hang guard
	task automatic summarize;
		if (mismatches == 0 && samples_checked > 0) begin
			$display("DONE - PASS");
		end else begin
			$display("DONE - FAIL");
		end
		$finish;
	endtask : summarize
	task automatic tmo(input int n);
		if (n > 100) begin
			mismatches++;
			summarize();
		end
	endtask : tmo
	// Expected read image
	function automatic logic [31:0] exp_rd(input logic [7:0] a);
		case (a)
			8'h00: return 32'(ctl | 8'h70);
			8'h04: return 32'(fl | 8'hFC);
			8'h08: return 32'(ist);
			8'h0C: return 32'(msk);
			default: return 32'h0;
		endcase
	endfunction : exp_rd
	// Write effect on the model
	function automatic void mdl_wr(input logic [7:0] a, input logic [31:0] v);
		case (a)
			8'h00: ctl = v & 8'h8F;
			8'h04: begin
				fl = fl & ~(hist & ~v[1:0]);
				hist = 0;
			end
			8'h08: ist = ist & ~v[1:0];
			8'h0C: msk = v[1:0];
			default: ;
		endcase
	endfunction : mdl_wr
	// ==========================================================
	// Bus cycles, each released only when taken
	task automatic wr(input logic [7:0] a, input logic [31:0] v, input lvd_resp_t er);
		int n;
		n = 0;
		@(posedge clk_sys);
		s_axi_awaddr <= a;
		s_axi_wdata <= v;
		s_axi_awvalid <= 1'b1;
		s_axi_wvalid <= 1'b1;
		s_axi_bready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_awready) s_axi_awvalid <= 1'b0;
			if (s_axi_wready) s_axi_wvalid <= 1'b0;
			tmo(n);
		end while (!s_axi_bvalid);
		s_axi_bready <= 1'b0;
		`CHK(s_axi_bresp, er)
		mdl_wr(a, v);
	endtask : wr
	task automatic rd(input logic [7:0] a);
		int n;
		logic [31:0] e;
		n = 0;
		e = exp_rd(a);
		@(posedge clk_sys);
		s_axi_araddr <= a;
		s_axi_arvalid <= 1'b1;
		s_axi_rready <= 1'b1;
		do begin
			@(posedge clk_sys);
			n++;
			if (s_axi_arready) s_axi_arvalid <= 1'b0;
			tmo(n);
		end while (!s_axi_rvalid);
		s_axi_rready <= 1'b0;
		`CHK(s_axi_rdata, e)
		`CHK(s_axi_rresp, (a > 8'h0C) ? 2'h2 : 2'h0)
		if (a == 8'h04) hist = fl;
	endtask : rd
	// Move the supply, count request pulses
	task automatic supply(input logic [15:0] v, input int ep);
		@(posedge clk_sys);
		mv <= v;
		pulses = 0;
		repeat (8) begin
			@(posedge clk_sys);
			if (external_irq_zero === 1'b1) pulses++;
		end
		`CHK(pulses, ep)
	endtask : supply
	task automatic irq_is(input logic e);
		repeat (3) @(posedge clk_sys);
		`CHK(irq, e)
	endtask : irq_is
	// ==========================================================
	// Main sequence
	initial begin
		void'($urandom(32'h1FF819A9));
		repeat (10) @(posedge clk_sys);
		rst <= 1'b0;
		rd(8'h00);
		rd(8'h04);
		rd(8'h0C);
		wr(8'h00, 32'h80, 2'h0);
		repeat (1000) @(posedge clk_sys);
		// Legal settings, junk in fixed bits
		for (int i = 0; i < 12; i++) begin
			d = ($urandom & 32'hFFFFFF70) | legal[i % 4];
			wr(8'h00, d, 2'h0);
			rd(8'h00);
			`CHK(reset_threshold_select, d[3])
		end
		wr(8'h00, 32'h83, 2'h0);
		wr(8'h0C, 32'h3, 2'h0);
		supply(3500, 1);
		fl = 2;
		ist = 1;
		irq_is(1'b1);
		wr(8'h04, 32'hFF, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		rd(8'h04);
		wr(8'h04, 32'h0, 2'h0);
		rd(8'h04);
		supply(4200, 1);
		fl = 1;
		ist = 3;
		rd(8'h04);
		rd(8'h08);
		// Masked source still latches
		wr(8'h08, 32'h3, 2'h0);
		irq_is(1'b0);
		wr(8'h0C, 32'h0, 2'h0);
		wr(8'h04, 32'h0, 2'h0);
		supply(3500, 1);
		fl = 2;
		ist = 1;
		irq_is(1'b0);
		wr(8'h0C, 32'h1, 2'h0);
		irq_is(1'b1);
		wr(8'h08, 32'h1, 2'h0);
		irq_is(1'b0);
		supply(4200, 1);
		fl = 3;
		ist = 2;
		rd(8'h04);
		wr(8'h04, 32'h0, 2'h0);
		wr(8'h08, 32'h3, 2'h0);
		// Dip under reset level, reset disabled
		supply(2000, 1);
		`CHK(undervolt_reset_function, 1'b0)
		supply(4200, 0);
		fl = 2;
		ist = 1;
		rd(8'h04);
		wr(8'h04, 32'h0, 2'h0);
		// Interrupt enables off, reset enabled at high level
		wr(8'h00, 32'h8C, 2'h0);
		supply(3650, 0);
		fl = 2;
		rd(8'h08);
		supply(4200, 0);
		rd(8'h04);
		supply(3000, 0);
		fl = 0;
		hist = 0;
		`CHK(undervolt_reset_function, 1'b1)
		rd(8'h00);
		rd(8'h04);
		supply(4200, 0);
		`CHK(undervolt_reset_function, 1'b0)
		rd(8'h10);
		wr(8'h10, 32'hFF, 2'h2);
		// Watchdog clears everything
		@(posedge clk_sys);
		wdt_rst <= 1'b1;
		repeat (2) @(posedge clk_sys);
		wdt_rst <= 1'b0;
		ctl = 0;
		ist = 0;
		msk = 0;
		rd(8'h00);
		`CHK(monitor_master_enable, 1'b0)
		summarize();
	end
endmodule : tb_top
